// ===== hdl/adc_i2c_pkg.sv
// Purpose: shared constants and types of the converter's two-wire target port
// Assumes: 25 MHz system clock, bus clock arrives on its own pin
// Notes: conversion interval is set by the converter's done handshake
package adc_i2c_pkg;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_SWRST = 8'h06;
  localparam logic [7:0] GC_ADDR_UPD = 8'h04;
  // master codes 0x08..0x0F share these top five bits
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] OP_RD1 = 8'h10;
  localparam logic [7:0] OP_WR1 = 8'h08;
  localparam logic [7:0] OP_SET = 8'h18;
  localparam logic [7:0] OP_CLR = 8'h20;
  localparam logic [7:0] OP_RDBLK = 8'h30;
  localparam logic [7:0] OP_WRBLK = 8'h28;
  localparam logic [6:0] TADDR_SEL0 = 7'h17;
  localparam logic [6:0] TADDR_SEL1 = 7'h14;
  localparam logic [6:0] TADDR_SEL2 = 7'h10;
  localparam logic [6:0] TADDR_SEL3 = 7'h13;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [1:0] LATCH_AT = 2'h2;
  localparam logic [1:0] LATCH_DONE = 2'h3;
  localparam logic [7:0] PTR_RESET = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_GCALL, ST_OPC, ST_RADDR, ST_WDATA,
    ST_RTX, ST_CONV, ST_CTX, ST_IGNORE
  } state_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic done;
    logic [11:0] code;
  } conv_res_t;
endpackage

// ===== hdl/scl_bit_sampler.sv
// Purpose: bit sampler running on the bus clock itself
// Assumes: data is valid at every rising bus clock edge
// Notes: byte_o is stable for a whole bus clock period after tgl_o flips
`timescale 1ns/100ps
`default_nettype none
module scl_bit_sampler (
  input wire logic scl_clk_i,
  input wire logic resetn_i,
  input wire logic sda_i,
  output logic [7:0] byte_o,
  output logic tgl_o
);
  always_ff @(posedge scl_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      byte_o <= 8'h00;
      tgl_o <= 1'b0;
    end
    else
    begin
      byte_o <= {byte_o[6:0], sda_i};
      tgl_o <= ~tgl_o;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/adc_i2c_target.sv
// Purpose: two-wire target command port of an eight-channel 12-bit converter
// Assumes: register file and converter sit outside, on sys_clk_i
// Notes: SDA and SCL are open drain; only low is ever driven
`timescale 1ns/100ps
`default_nettype none
module adc_i2c_target
  import adc_i2c_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_sel_i,
  input wire logic [7:0] reg_rdata_i,
  input wire conv_res_t conv_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  output var reg_req_t reg_req_o,
  output logic conv_start_o,
  output logic sw_reset_o,
  output logic hs_mode_o
);
  logic [7:0] link_byte;
  logic link_tgl;
  logic tgl_s1, tgl_s2, tgl_s3;
  logic scl_s1, scl_s2, scl_s3, scl_s4;
  logic sda_s1, sda_s2, sda_s3;
  logic [1:0] asel_s1, asel_s2;
  logic rise_ev, fall_ev, start_det, stop_det, take, m_ack;
  state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_byte_reg, tx_byte_reg, op_reg, ptr_reg, res_hi;
  logic byte_done_reg, ack_reg, have_raddr_reg, res_second_reg;
  logic rel_pend_reg, relatch_reg, legal_op, is_read_op, conv_done;
  logic [3:0] res_lo_reg;
  logic [6:0] taddr_reg, lut_addr;
  logic [1:0] init_cnt_reg;

  scl_bit_sampler u_sampler (
    .scl_clk_i(scl_i),
    .resetn_i(resetn_i),
    .sda_i(sda_i),
    .byte_o(link_byte),
    .tgl_o(link_tgl)
  );

  // pins and the sampler toggle pass two flops before use
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      {tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
      {scl_s1, scl_s2, scl_s3, scl_s4} <= 4'hF;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      asel_s1 <= 2'h0;
      asel_s2 <= 2'h0;
    end
    else
    begin
      {tgl_s1, tgl_s2, tgl_s3} <= {link_tgl, tgl_s1, tgl_s2};
      {scl_s1, scl_s2, scl_s3, scl_s4} <= {scl_i, scl_s1, scl_s2, scl_s3};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      asel_s1 <= addr_sel_i;
      asel_s2 <= asel_s1;
    end
  end

  assign rise_ev = tgl_s2 ^ tgl_s3;
  // one extra stage so ack and data decisions settle before we drive
  assign fall_ev = scl_s4 & ~scl_s3;
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign take = byte_done_reg & ~start_det & ~stop_det;
  // link_byte is only read while the toggle says it has settled
  assign m_ack = ~link_byte[0];
  assign res_hi = conv_i.code[11:4];
  assign conv_done = (state_reg == ST_CONV) & scl_oe_o & conv_i.done;
  assign is_read_op = (op_reg == OP_RD1) | (op_reg == OP_RDBLK);
  assign legal_op = (rx_byte_reg == OP_RD1) | (rx_byte_reg == OP_WR1) | (rx_byte_reg == OP_SET)
                  | (rx_byte_reg == OP_CLR) | (rx_byte_reg == OP_RDBLK) | (rx_byte_reg == OP_WRBLK);
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  always_comb
  begin
    unique case (asel_s2)
      2'h0: lut_addr = TADDR_SEL0;
      2'h1: lut_addr = TADDR_SEL1;
      2'h2: lut_addr = TADDR_SEL2;
      2'h3: lut_addr = TADDR_SEL3;
    endcase
  end

  // bit framing
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_cnt_reg <= 4'h0;
      byte_done_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
    end
    else
    begin
      byte_done_reg <= rise_ev & (bit_cnt_reg == LAST_DATA_BIT) & ~start_det & ~stop_det;
      if (rise_ev && bit_cnt_reg == LAST_DATA_BIT)
        rx_byte_reg <= link_byte;
      if (start_det || stop_det)
        bit_cnt_reg <= 4'h0;
      else if (rise_ev)
        bit_cnt_reg <= (bit_cnt_reg == ACK_SLOT) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // command decoder
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      op_reg <= 8'h00;
      ptr_reg <= PTR_RESET;
      have_raddr_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      res_lo_reg <= 4'h0;
      res_second_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= ST_ADDR;
      ack_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      have_raddr_reg <= 1'b0;
    end
    else if (take)
    begin
      unique case (state_reg)
        ST_ADDR:
        begin
          ack_reg <= 1'b0;
          state_reg <= ST_IGNORE;
          if (rx_byte_reg == GC_ADDR)
          begin
            ack_reg <= 1'b1;
            state_reg <= ST_GCALL;
          end
          else if (rx_byte_reg[7:1] == taddr_reg)
          begin
            ack_reg <= 1'b1;
            if (!rx_byte_reg[0])
              state_reg <= ST_OPC;
            else if (is_read_op && have_raddr_reg)
            begin
              state_reg <= ST_RTX;
              tx_byte_reg <= reg_rdata_i;
              if (op_reg == OP_RDBLK)
                ptr_reg <= ptr_reg + 8'h01;
            end
            else
              state_reg <= ST_CONV;
          end
        end
        ST_GCALL:
        begin
          ack_reg <= (rx_byte_reg == GC_SWRST) | (rx_byte_reg == GC_ADDR_UPD);
          state_reg <= ST_IGNORE;
        end
        ST_OPC:
        begin
          op_reg <= rx_byte_reg;
          ack_reg <= legal_op;
          have_raddr_reg <= 1'b0;
          state_reg <= legal_op ? ST_RADDR : ST_IGNORE;
        end
        ST_RADDR:
        begin
          ptr_reg <= rx_byte_reg;
          have_raddr_reg <= 1'b1;
          ack_reg <= 1'b1;
          state_reg <= ST_WDATA;
        end
        ST_WDATA:
        begin
          // a read opcode expects a repeated start here, not data
          ack_reg <= ~is_read_op;
          if (op_reg == OP_WRBLK)
            ptr_reg <= ptr_reg + 8'h01;
          else
            state_reg <= ST_IGNORE;
        end
        ST_IDLE, ST_RTX, ST_CONV, ST_CTX, ST_IGNORE:
          ack_reg <= 1'b0;
      endcase
    end
    else if (rise_ev && bit_cnt_reg == ACK_SLOT)
    begin
      ack_reg <= 1'b0;
      // our own ack slot carries ack_reg; only the others are the controller's
      if (!ack_reg && state_reg == ST_RTX)
      begin
        if (m_ack)
        begin
          tx_byte_reg <= reg_rdata_i;
          if (op_reg == OP_RDBLK)
            ptr_reg <= ptr_reg + 8'h01;
        end
        else
          state_reg <= ST_IGNORE;
      end
      else if (!ack_reg && state_reg == ST_CTX)
      begin
        if (!m_ack)
          state_reg <= ST_IGNORE;
        else if (!res_second_reg)
        begin
          tx_byte_reg <= {res_lo_reg, 4'h0};
          res_second_reg <= 1'b1;
        end
        else
          state_reg <= ST_CONV;
      end
    end
    else if (conv_done)
    begin
      state_reg <= ST_CTX;
      tx_byte_reg <= res_hi;
      res_lo_reg <= conv_i.code[3:0];
      res_second_reg <= 1'b0;
    end
  end

  // data line: ack, transmit bits, released at start and stop
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sda_oe_o <= 1'b0;
    else if (start_det || stop_det)
      sda_oe_o <= 1'b0;
    else if (conv_done)
      sda_oe_o <= ~res_hi[7];
    else if (fall_ev)
    begin
      if (bit_cnt_reg == ACK_SLOT)
        sda_oe_o <= ack_reg;
      else if (state_reg == ST_RTX || state_reg == ST_CTX)
        sda_oe_o <= ~tx_byte_reg[~bit_cnt_reg[2:0]];
      else
        sda_oe_o <= 1'b0;
    end
  end

  // clock stretch; SCL is released one cycle after SDA has its first result bit
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_oe_o <= 1'b0;
      rel_pend_reg <= 1'b0;
      conv_start_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      if (rel_pend_reg)
      begin
        scl_oe_o <= 1'b0;
        rel_pend_reg <= 1'b0;
      end
      else if (conv_done)
        rel_pend_reg <= 1'b1;
      else if (fall_ev && state_reg == ST_CONV && bit_cnt_reg == 4'h0 && !scl_oe_o)
      begin
        scl_oe_o <= 1'b1;
        conv_start_o <= 1'b1;
      end
    end
  end

  // register requests; set and clear are read-modify-write on reg_rdata_i
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_req_o <= '0;
    else
    begin
      reg_req_o.we <= 1'b0;
      reg_req_o.addr <= ptr_reg;
      if (take && state_reg == ST_WDATA && !is_read_op)
      begin
        reg_req_o.we <= 1'b1;
        if (op_reg == OP_SET)
          reg_req_o.wdata <= reg_rdata_i | rx_byte_reg;
        else if (op_reg == OP_CLR)
          reg_req_o.wdata <= reg_rdata_i & ~rx_byte_reg;
        else
          reg_req_o.wdata <= rx_byte_reg;
      end
    end
  end

  // general call commands
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sw_reset_o <= 1'b0;
      relatch_reg <= 1'b0;
    end
    else
    begin
      sw_reset_o <= take & (state_reg == ST_GCALL) & (rx_byte_reg == GC_SWRST);
      relatch_reg <= take & (state_reg == ST_GCALL)
                   & ((rx_byte_reg == GC_SWRST) | (rx_byte_reg == GC_ADDR_UPD));
    end
  end

  // target address: strap caught after release, again on request
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      init_cnt_reg <= 2'h0;
      taddr_reg <= TADDR_SEL0;
    end
    else
    begin
      if (init_cnt_reg != LATCH_DONE)
        init_cnt_reg <= init_cnt_reg + 2'h1;
      if (relatch_reg || init_cnt_reg == LATCH_AT)
        taddr_reg <= lut_addr;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hs_mode_o <= 1'b0;
    else if (stop_det)
      hs_mode_o <= 1'b0;
    else if (take && state_reg == ST_ADDR && rx_byte_reg[7:3] == HS_CODE_TOP)
      hs_mode_o <= 1'b1;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_gc(logic [7:0] v);
    take && state_reg == ST_GCALL && rx_byte_reg == v;
  endsequence
  sequence s_wdata(logic [7:0] op);
    take && state_reg == ST_WDATA && op_reg == op;
  endsequence
  sequence s_read_addr;
    take && state_reg == ST_ADDR && rx_byte_reg == {taddr_reg, 1'b1};
  endsequence

  a_gc_swreset: assert property (s_gc(GC_SWRST) |=> sw_reset_o && relatch_reg)
    else $error("software reset not issued");
  a_addr_update: assert property (s_gc(GC_ADDR_UPD) |=> relatch_reg ##1 taddr_reg == $past(lut_addr))
    else $error("address not re-latched");
  a_hs_enter: assert property (take && state_reg == ST_ADDR && rx_byte_reg[7:3] == HS_CODE_TOP
                               |=> hs_mode_o && !ack_reg)
    else $error("master code not taken");
  a_hs_hold: assert property (hs_mode_o && !stop_det |=> hs_mode_o)
    else $error("high-speed mode left without stop");
  a_result_read: assert property (s_read_addr and !(is_read_op && have_raddr_reg)
                                  |=> state_reg == ST_CONV)
    else $error("bare read did not start conversion");
  a_single_read: assert property (s_read_addr and (op_reg == OP_RD1 && have_raddr_reg)
                                  |=> state_reg == ST_RTX && tx_byte_reg == $past(reg_rdata_i))
    else $error("register byte not loaded");
  a_block_read: assert property (s_read_addr and (op_reg == OP_RDBLK && have_raddr_reg)
                                 |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("block read pointer not advanced");
  a_stretch_hold: assert property (state_reg == ST_CONV && scl_oe_o && !conv_i.done |=> scl_oe_o)
    else $error("clock released before conversion end");
  a_stretch_release: assert property (conv_done |=> (state_reg == ST_CTX && scl_oe_o) ##1 !scl_oe_o)
    else $error("clock not released after conversion");
  a_result_msb: assert property (conv_done |=> tx_byte_reg == $past(res_hi) && sda_oe_o == !$past(res_hi[7]))
    else $error("result high byte wrong");
  a_opcode_ack: assert property (take && state_reg == ST_OPC |=> ack_reg == $past(legal_op))
    else $error("opcode acknowledge wrong");
  a_single_write: assert property (s_wdata(OP_WR1) |=> reg_req_o.we && reg_req_o.wdata == $past(rx_byte_reg)
                                   && state_reg == ST_IGNORE)
    else $error("single write wrong");
  a_set_bits: assert property (s_wdata(OP_SET) |=> reg_req_o.we
                               && reg_req_o.wdata == ($past(reg_rdata_i) | $past(rx_byte_reg)))
    else $error("set bits wrong");
  a_clear_bits: assert property (s_wdata(OP_CLR) |=> reg_req_o.we
                                 && reg_req_o.wdata == ($past(reg_rdata_i) & ~$past(rx_byte_reg)))
    else $error("clear bits wrong");
  a_block_write: assert property (s_wdata(OP_WRBLK) |=> reg_req_o.we && reg_req_o.addr == $past(ptr_reg)
                                  && ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("block write address wrong");
endmodule
`default_nettype wire

// ===== sim/i2c_ctrl_model.sv
// Purpose: two-wire bus controller model facing the target port
// Assumes: open-drain wires resolved in the bench, pulled high when released
// Notes: timing built from the link tick; SCL stands still between frames
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_model (
  input wire logic tck_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic stuck_o
);
  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    stuck_o = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge tck_i);
  endtask
  // the target may stretch the low phase, so follow the wire, bounded
  task automatic scl_up();
    int n;
    n = 0;
    scl_oe_o <= 1'b0;
    @(posedge tck_i);
    while (scl_i !== 1'b1 && n < 20000)
    begin
      n++;
      @(posedge tck_i);
    end
    if (n >= 20000)
      stuck_o <= 1'b1;
  endtask
  task automatic bus_bit(input logic tx, output logic rx);
    sda_oe_o <= ~tx;
    ticks(20);
    scl_up();
    ticks(25);
    rx = sda_i;
    scl_oe_o <= 1'b1;
    ticks(20);
  endtask
  // serves as start and as repeated start
  task automatic bus_start();
    sda_oe_o <= 1'b0;
    // target may hold its ack up to 160 ns past the fall; SDA must be high before SCL rises
    ticks(25);
    scl_up();
    ticks(30);
    sda_oe_o <= 1'b1;
    ticks(30);
    scl_oe_o <= 1'b1;
    ticks(20);
  endtask
  task automatic bus_stop();
    sda_oe_o <= 1'b1;
    ticks(20);
    scl_up();
    ticks(30);
    sda_oe_o <= 1'b0;
    ticks(40);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bus_bit(b[i], r);
    bus_bit(1'b1, nak);
  endtask
  task automatic get_byte(output logic [7:0] b, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bus_bit(1'b1, b[i]);
    bus_bit(nak, r);
  endtask
endmodule
`default_nettype wire

// ===== sim/test_adc_i2c_target.sv
// Purpose: self-checking bench of the converter's two-wire target port
// Assumes: register file and converter are modelled here on sys_clk_i
// Notes: expected register contents kept in an integer array
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_adc_i2c_target
  import adc_i2c_pkg::*;
();
  logic sys_clk_i, resetn_i, tck, sda_o, sda_oe, scl_o, scl_oe, conv_start, sw_reset, hs_mode;
  logic m_scl_oe, m_sda_oe, stuck, scl_w, sda_w, conv_busy;
  logic [1:0] addr_sel;
  logic [6:0] taddr, old;
  logic [7:0] reg_rdata, ra, d, op;
  logic [11:0] conv_code;
  logic [7:0] dev_regs [256];
  logic [7:0] wq [$];
  conv_res_t conv;
  reg_req_t reg_req;
  int exp_regs [256];
  int bad_count, comparisons, cycles, sw_pulses, sw0, conv_delay, conv_left, stretch;
  int seed;
  // a pin driver only pulls low when its level output is low too
  assign scl_w = ~((scl_oe & ~scl_o) | m_scl_oe);
  assign sda_w = ~((sda_oe & ~sda_o) | m_sda_oe);
  assign reg_rdata = dev_regs[reg_req.addr];
  adc_i2c_target dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl_w), .sda_i(sda_w),
    .addr_sel_i(addr_sel), .reg_rdata_i(reg_rdata), .conv_i(conv), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .reg_req_o(reg_req), .conv_start_o(conv_start),
    .sw_reset_o(sw_reset), .hs_mode_o(hs_mode));
  i2c_ctrl_model u_ctrl (.tck_i(tck), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe),
    .sda_oe_o(m_sda_oe), .stuck_o(stuck));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    tck = 1'b0;
    #1.7;
    forever #3 tck = ~tck;
  end
  // register file and converter stand-ins
  always @(posedge sys_clk_i)
  begin
    cycles++;
    conv.done <= 1'b0;
    if (reg_req.we)
      dev_regs[reg_req.addr] <= reg_req.wdata;
    if (sw_reset)
      sw_pulses++;
    if (conv_start)
    begin
      conv_left <= conv_delay;
      conv_busy <= 1'b1;
      stretch <= 0;
    end
    else if (conv_busy)
    begin
      if (scl_oe)
        stretch <= stretch + 1;
      if (conv_left == 0)
      begin
        conv_busy <= 1'b0;
        conv.done <= 1'b1;
        conv.code <= conv_code;
      end
      else
        conv_left <= conv_left - 1;
    end
    if (cycles == 40000 || stuck)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [6:0] tgt(input logic [1:0] s);
    case (s)
      2'h0: return TADDR_SEL0;
      2'h1: return TADDR_SEL1;
      2'h2: return TADDR_SEL2;
      default: return TADDR_SEL3;
    endcase
  endfunction
  task automatic send(input logic [7:0] b, input logic exp_nak);
    logic nak;
    u_ctrl.put_byte(b, nak);
    `CHK(nak, exp_nak)
  endtask
  task automatic wr_frame(input logic [7:0] opc, input logic [7:0] adr);
    u_ctrl.bus_start();
    send({taddr, 1'b0}, 1'b0);
    send(opc, 1'b0);
    send(adr, 1'b0);
    foreach (wq[j])
      send(wq[j], 1'b0);
    u_ctrl.bus_stop();
  endtask
  task automatic rd_frame(input logic [7:0] opc, input logic [7:0] adr, input int n);
    logic [7:0] b;
    u_ctrl.bus_start();
    send({taddr, 1'b0}, 1'b0);
    send(opc, 1'b0);
    send(adr, 1'b0);
    u_ctrl.bus_start();
    send({taddr, 1'b1}, 1'b0);
    for (int j = 0; j < n; j++)
    begin
      u_ctrl.get_byte(b, j == n - 1);
      `CHK(b, exp_regs[8'(adr + j)][7:0])
    end
    u_ctrl.bus_stop();
  endtask
  task automatic read_result();
    logic [7:0] hi, lo;
    conv_code = 12'($random(seed));
    conv_delay = 5 + ($unsigned($random(seed)) % 40);
    u_ctrl.bus_start();
    send({taddr, 1'b1}, 1'b0);
    u_ctrl.get_byte(hi, 1'b0);
    `CHK(hi, conv_code[11:4])
    `CHK(stretch >= conv_delay, 1'b1)
    u_ctrl.get_byte(lo, 1'b1);
    `CHK(lo, {conv_code[3:0], 4'h0})
    u_ctrl.bus_stop();
  endtask
  initial
  begin
    seed = 32'h6f5c;
    resetn_i = 1'b0;
    addr_sel = 2'h0;
    conv = '0;
    conv_code = 12'h000;
    conv_busy = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      dev_regs[i] = 8'($random(seed));
      exp_regs[i] = dev_regs[i];
    end
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    `CHK(hs_mode, 1'b0)
    for (int k = 1; k <= 4; k++)
    begin
      old = tgt(addr_sel);
      @(posedge sys_clk_i);
      addr_sel <= k[1:0];
      repeat (5) @(posedge sys_clk_i);
      sw0 = sw_pulses;
      // strap change alone must not move the address until a reload
      taddr = old;
      read_result();
      u_ctrl.bus_start();
      send(GC_ADDR, 1'b0);
      send((k == 2) ? GC_SWRST : GC_ADDR_UPD, 1'b0);
      u_ctrl.bus_stop();
      `CHK(sw_pulses - sw0, (k == 2) ? 1 : 0)
      taddr = tgt(k[1:0]);
      u_ctrl.bus_start();
      send({old, 1'b0}, 1'b1);
      u_ctrl.bus_stop();
      for (int i = 0; i < 4; i++)
      begin
        ra = 8'($random(seed)) & 8'h3F;
        d = 8'($random(seed));
        op = (i == 0) ? OP_WR1 : (i == 1) ? OP_SET : (i == 2) ? OP_CLR : OP_WR1;
        case (op)
          OP_SET: exp_regs[ra] = exp_regs[ra] | d;
          OP_CLR: exp_regs[ra] = exp_regs[ra] & ~d;
          default: exp_regs[ra] = d;
        endcase
        wq.delete();
        wq.push_back(d);
        wr_frame(op, ra);
        rd_frame(OP_RD1, ra, 1);
      end
      ra = 8'($random(seed)) & 8'h3F;
      wq.delete();
      for (int j = 0; j < 3; j++)
      begin
        wq.push_back(8'($random(seed)));
        exp_regs[8'(ra + j)] = wq[j];
      end
      wr_frame(OP_WRBLK, ra);
      rd_frame(OP_RDBLK, ra, 3);
    end
    // an opcode outside the command set is refused
    u_ctrl.bus_start();
    send({taddr, 1'b0}, 1'b0);
    send(8'h11, 1'b1);
    u_ctrl.bus_stop();
    for (int c = 8; c < 16; c++)
    begin
      u_ctrl.bus_start();
      send(8'(c), 1'b1);
      `CHK(hs_mode, 1'b1)
      u_ctrl.bus_start();
      send({taddr, 1'b0}, 1'b0);
      `CHK(hs_mode, 1'b1)
      u_ctrl.bus_stop();
      `CHK(hs_mode, 1'b0)
    end
    summarize();
  end
endmodule
`default_nettype wire
